/* design/fswp_pkg.sv */
// Package for the sector write-protect checker: constants and carriers.
// Assumes a 24-bit byte address and 128 sectors of 64KB.
package fswp_pkg;
  localparam int ADDR_W = 24;
  localparam int SEC_W = 7;
  localparam int SUB_W = 11;
  localparam int NUM_SEC = 128;
  localparam int SEC_LSB = 16;
  localparam int SUB_LSB = 12;
  localparam logic [23:0] ADDR_TOP = 24'h7FFFFF;
  localparam logic [2:0] BYTE_MASK = 3'h7;
  localparam int PROTECT_ALL_BIT = 3;

  typedef enum logic [2:0] {
    FSWP_OP_PROG = 3'h1,
    FSWP_OP_ERASE = 3'h2,
    FSWP_OP_LOCKWR = 3'h4
  } fswp_op_t;

  typedef struct packed {
    logic valid;
    fswp_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [2:0] bit_count_low;
    logic lock_value;
    logic lockdown_value;
  } fswp_req_t;

  typedef struct packed {
    logic valid;
    logic granted;
    logic [SEC_W-1:0] sector;
    logic [SUB_W-1:0] subsector;
  } fswp_resp_t;

  typedef struct packed {
    logic top_bottom;
    logic protect_size_bit3;
    logic protect_size_bit2;
    logic protect_size_bit1;
    logic protect_size_bit0;
    logic write_enable_latch;
  } fswp_status_t;

  typedef enum logic [2:0] {
    FSWP_ST_POWERUP = 3'h1,
    FSWP_ST_IDLE = 3'h2,
    FSWP_ST_ANSWER = 3'h4
  } fswp_state_t;

  typedef struct packed {
    fswp_state_t state;
    logic [NUM_SEC-1:0] lock;
    logic [NUM_SEC-1:0] lockdown;
    fswp_resp_t resp;
  } fswp_regs_t;
endpackage

/* design/fswp_checker.sv */
// Sector write-protect checker: decides whether a modifying command runs.
// Assumes requests are already decoded and synchronous to ref_clk.
`timescale 1ns/1ns
module fswp_checker
  import fswp_pkg::*;
(
  input wire logic ref_clk, // 25 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic supply_ok, // Start-up timer done, supply in range
  input wire fswp_pkg::fswp_req_t req, // Decoded command request
  input wire fswp_pkg::fswp_status_t status, // Status register fields
  input wire logic write_protect_n, // Write-protect pin, low locks area
  input wire logic quad_mode, // Quad protocol active, pin is data
  input wire logic status_write, // Host asks to write status register
  output fswp_pkg::fswp_resp_t resp, // Grant answer, one cycle
  output logic status_write_ok, // Status write may proceed
  output logic [fswp_pkg::NUM_SEC-1:0] sector_lock, // Lock bits
  output logic [fswp_pkg::NUM_SEC-1:0] sector_lockdown // Lock-down bits
);
  import fswp_pkg::*;

  fswp_regs_t s_r;
  fswp_regs_t s_nxt;
  logic [SEC_W-1:0] sec;
  logic [SUB_W-1:0] sub;
  logic [3:0] bp;
  logic [SEC_W:0] span;
  logic in_area;
  logic whole_bytes;
  logic may_modify;
  logic is_array_op;
  logic taken;

  assign sec = req.addr[SEC_LSB +: SEC_W];
  assign sub = req.addr[SUB_LSB +: SUB_W];
  assign bp = {status.protect_size_bit3, status.protect_size_bit2,
               status.protect_size_bit1, status.protect_size_bit0};
  assign whole_bytes = (req.bit_count_low & BYTE_MASK) == 3'h0;
  assign may_modify = supply_ok && status.write_enable_latch && whole_bytes
                      && (s_r.state == FSWP_ST_IDLE);
  assign is_array_op = (req.op == FSWP_OP_PROG) || (req.op == FSWP_OP_ERASE);
  assign taken = (s_r.state == FSWP_ST_IDLE) && req.valid;

  always_comb begin
    span = '0;
    in_area = 1'b0;
    if (bp[PROTECT_ALL_BIT]) begin
      in_area = 1'b1;
    end else if (bp != 4'h0) begin
      span = 8'(8'h01 << (bp[2:0] - 3'h1));
      if (status.top_bottom) begin
        in_area = {1'b0, sec} < span;
      end else begin
        in_area = {1'b0, sec} >= 8'(8'h80 - span);
      end
    end
  end

  // Pin low in single/dual modes holds the area fixed against writes
  assign status_write_ok = status_write && supply_ok
    && status.write_enable_latch && (write_protect_n || quad_mode);

  always_comb begin
    s_nxt = s_r;
    s_nxt.resp = '0;
    case (s_r.state)
      FSWP_ST_POWERUP: begin
        if (supply_ok) begin
          s_nxt.state = FSWP_ST_IDLE;
        end
      end
      FSWP_ST_IDLE: begin
        if (req.valid) begin
          s_nxt.state = FSWP_ST_ANSWER;
          s_nxt.resp.valid = 1'b1;
          s_nxt.resp.sector = sec;
          s_nxt.resp.subsector = sub;
          if (is_array_op) begin
            s_nxt.resp.granted = may_modify && !in_area
                                 && !s_r.lock[sec];
          end else if (req.op == FSWP_OP_LOCKWR) begin
            if (may_modify && !s_r.lockdown[sec]) begin
              s_nxt.resp.granted = 1'b1;
              s_nxt.lock[sec] = req.lock_value;
              s_nxt.lockdown[sec] = req.lockdown_value;
            end
          end
        end
      end
      FSWP_ST_ANSWER: begin
        s_nxt.state = FSWP_ST_IDLE;
      end
      default: begin
        s_nxt.state = FSWP_ST_POWERUP;
      end
    endcase
    if (!supply_ok) begin
      s_nxt.state = FSWP_ST_POWERUP;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_r <= '{state: FSWP_ST_POWERUP, lock: '0, lockdown: '0, resp: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign resp = s_r.resp;
  assign sector_lock = s_r.lock;
  assign sector_lockdown = s_r.lockdown;

  // Request taken on this edge
  sequence s_taken;
    taken;
  endsequence

  // Answer stands exactly one cycle
  sequence s_answer_pulse;
    resp.valid ##1 !resp.valid;
  endsequence

  // Lock write that passes every check
  sequence s_lockwr_ok;
    taken && req.op == FSWP_OP_LOCKWR && may_modify && !s_r.lockdown[sec];
  endsequence

  // Array write inside the block-protect area
  sequence s_array_in_area;
    taken && is_array_op && in_area;
  endsequence

  chk_grant_needs_wel: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (s_r.state == FSWP_ST_IDLE && req.valid && !status.write_enable_latch)
    |=> !resp.granted) else $error("grant without write enable");
  chk_partial_byte_refused: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (req.valid && req.bit_count_low != 3'h0)
    |=> !resp.granted) else $error("grant on partial byte");
  chk_powerup_no_grant: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !supply_ok |=> !resp.granted)
    else $error("grant before supply ready");
  chk_locked_sector_blocked: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (req.valid && is_array_op && sector_lock[sec])
    |=> !resp.granted) else $error("locked sector granted");
  chk_lockdown_frozen: assert property (
    @(posedge ref_clk) disable iff (!resetn) sector_lockdown[sec]
    |=> sector_lock[$past(sec)] == $past(sector_lock[sec]))
    else $error("locked-down sector changed");
  chk_lock_only_by_cmd: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !(req.valid && req.op == FSWP_OP_LOCKWR)
    |=> $stable(sector_lock)) else $error("lock changed without cmd");
  chk_lockwr_ignored: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (req.valid && req.op == FSWP_OP_LOCKWR && sector_lockdown[sec])
    |=> !resp.granted) else $error("lock write on locked-down sector");
  chk_all_protected: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (req.valid && is_array_op && status.protect_size_bit3)
    |=> !resp.granted) else $error("grant with all protected");
  chk_top_sector_area: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (req.valid && is_array_op && !status.top_bottom
    && bp == 4'h1 && sec == 7'h7F) |=> !resp.granted)
    else $error("top sector not protected");
  chk_bottom_sector_area: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (req.valid && is_array_op && status.top_bottom
    && bp == 4'h7 && sec == 7'h3F) |=> !resp.granted)
    else $error("bottom half not protected");
  chk_pin_locks_area: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (!write_protect_n && !quad_mode) |-> !status_write_ok)
    else $error("status write with pin low");
  chk_addr_map: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (s_r.state == FSWP_ST_IDLE && req.valid && req.addr == ADDR_TOP)
    |=> resp.sector == 7'h7F && resp.subsector == 11'h7FF)
    else $error("address map wrong");
  chk_answer_one_cycle: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_taken |=> s_answer_pulse)
    else $error("answer not a one-cycle pulse");
  chk_no_answer_untaken: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (s_r.state != FSWP_ST_IDLE) |=> !resp.valid)
    else $error("answer without accepted request");
  chk_supply_drop_state: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !supply_ok |=> s_r.state == FSWP_ST_POWERUP)
    else $error("supply loss did not hold off");
  chk_lockwr_applies: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_lockwr_ok |=> resp.granted
    && sector_lock[$past(sec)] == $past(req.lock_value)
    && sector_lockdown[$past(sec)] == $past(req.lockdown_value))
    else $error("lock write not applied");
  chk_lockdown_kept: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    sector_lockdown[sec] |=> sector_lockdown[$past(sec)])
    else $error("lock-down bit cleared");
  chk_area_refused: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_array_in_area |=> !resp.granted)
    else $error("protected area granted");
  chk_top_half_edge: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (taken && is_array_op && !status.top_bottom && bp == 4'h7
    && sec == 7'h40) |=> !resp.granted)
    else $error("upper half edge not protected");
  chk_bottom_first: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (taken && is_array_op && status.top_bottom && bp == 4'h1
    && sec == 7'h00) |=> !resp.granted)
    else $error("sector zero not protected");
  chk_no_area_granted: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (taken && is_array_op && bp == 4'h0 && may_modify && !sector_lock[sec])
    |=> resp.granted) else $error("unprotected write refused");
  chk_sub_in_sector: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_taken |=> resp.subsector[SUB_W-1:SUB_W-SEC_W] == resp.sector)
    else $error("subsector outside its sector");
  chk_status_needs_wel: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    status_write_ok |-> status.write_enable_latch && supply_ok)
    else $error("status write without enable");
  chk_quad_ignores_pin: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (status_write && supply_ok && status.write_enable_latch && quad_mode)
    |-> status_write_ok) else $error("quad mode status write refused");
endmodule

/* tb/fswp_host.sv */
// Host model: issues one decoded flash command per call.
// Assumes the bench reads the checker's answer right after each call returns.
`timescale 1ns/1ns
module fswp_host
  import fswp_pkg::*;
(
  input wire logic ref_clk, // Clock
  output fswp_pkg::fswp_req_t req // Command to checker
);
  import fswp_pkg::*;
  initial req = '0;
  task automatic send(fswp_op_t op, logic [23:0] a, logic [2:0] b,
    logic lv, logic ldv);
    @(posedge ref_clk);
    #1 req = '{1'b1, op, a, b, lv, ldv};
    @(posedge ref_clk);
    #1 req.valid = 1'b0;
    // Released address shows no stale value
    req.addr = ~a;
  endtask
endmodule

/* tb/tb_flash_sector_write_protect.sv */
// Bench for the sector write-protect checker.
// Assumes fswp_host drives req; answers come one cycle after acceptance.
`timescale 1ns/1ns
module tb_flash_sector_write_protect;
  import fswp_pkg::*;
  logic ref_clk = 0, resetn = 0, supply_ok = 0, prot;
  logic write_protect_n = 1, quad_mode = 0, status_write = 0;
  logic status_write_ok;
  logic [NUM_SEC-1:0] sector_lock, sector_lockdown;
  logic [7:0] sz;
  fswp_req_t req;
  fswp_resp_t resp;
  fswp_status_t status = '0;
  int err_count = 0, checks = 0, cyc = 0;
  fswp_checker u_dut (.ref_clk, .resetn, .supply_ok, .req, .status,
    .write_protect_n, .quad_mode, .status_write, .resp, .status_write_ok,
    .sector_lock, .sector_lockdown);
  fswp_host u_host (.ref_clk, .req);
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("err_count=%0d checks=%0d", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmd(fswp_op_t op, logic [23:0] a, logic [2:0] b,
    logic lv, logic ldv, logic g);
    u_host.send(op, a, b, lv, ldv);
    chk(resp.valid, 1);
    chk(resp.granted, g);
    chk({resp.sector, resp.subsector}, {a[22:16], a[22:12]});
  endtask
  task automatic boot();
    resetn = 0;
    repeat (4) @(posedge ref_clk);
    #1 resetn = 1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  initial begin
    boot();
    u_host.send(FSWP_OP_PROG, 24'h000000, 3'h0, 1'h0, 1'h0);
    chk(resp.valid, 0);
    supply_ok = 1;
    repeat (2) @(posedge ref_clk);
    cmd(FSWP_OP_PROG, 24'h010000, 3'h0, 1'h0, 1'h0, 1'h0);
    status.write_enable_latch = 1;
    cmd(FSWP_OP_PROG, 24'h020000, 3'h3, 1'h0, 1'h0, 1'h0);
    cmd(FSWP_OP_LOCKWR, 24'h020000, 3'h5, 1'h1, 1'h0, 1'h0);
    chk(sector_lock[2], 0);
    for (int t = 0; t < 2; t++) begin
      for (int bp = 0; bp < 16; bp++) begin
        status.top_bottom = t[0];
        {status.protect_size_bit3, status.protect_size_bit2,
          status.protect_size_bit1, status.protect_size_bit0} = bp[3:0];
        sz = bp[3] ? 8'h80 : (bp == 0) ? 8'h00 : 8'h01 << (bp - 1);
        for (int s = 0; s < 128; s++) begin
          prot = t[0] ? (s < sz) : (s >= 128 - sz);
          cmd(s[0] ? FSWP_OP_ERASE : FSWP_OP_PROG, {1'b0, s[6:0], 16'hFFFF},
            3'h0, 1'h0, 1'h0, !prot);
        end
      end
    end
    status = '0;
    status.write_enable_latch = 1;
    cmd(FSWP_OP_LOCKWR, 24'h050000, 3'h0, 1'h1, 1'h0, 1'h1);
    chk(sector_lock[5], 1);
    cmd(FSWP_OP_ERASE, 24'h05ABCD, 3'h0, 1'h0, 1'h0, 1'h0);
    cmd(FSWP_OP_PROG, 24'h04ABCD, 3'h0, 1'h0, 1'h0, 1'h1);
    cmd(FSWP_OP_LOCKWR, 24'h050000, 3'h0, 1'h0, 1'h0, 1'h1);
    cmd(FSWP_OP_PROG, 24'h05ABCD, 3'h0, 1'h0, 1'h0, 1'h1);
    cmd(FSWP_OP_LOCKWR, 24'h050000, 3'h0, 1'h1, 1'h1, 1'h1);
    chk({sector_lock[5], sector_lockdown[5]}, 3);
    cmd(FSWP_OP_LOCKWR, 24'h050000, 3'h0, 1'h0, 1'h0, 1'h0);
    chk(sector_lock[5], 1);
    cmd(FSWP_OP_PROG, 24'h05ABCD, 3'h0, 1'h0, 1'h0, 1'h0);
    boot();
    chk({sector_lock[5], sector_lockdown[5]}, 0);
    for (int i = 0; i < 16; i++) begin
      @(posedge ref_clk) #1 {status_write, status.write_enable_latch,
        write_protect_n, quad_mode} = i[3:0];
      #1 chk(status_write_ok, i[3] & i[2] & (i[1] | i[0]));
    end
    supply_ok = 0;
    #1 chk(status_write_ok, 0);
    u_host.send(FSWP_OP_PROG, 24'h040000, 3'h0, 1'h0, 1'h0);
    chk(resp.valid, 0);
    end_sim();
  end
endmodule
